// file: inc/gtop_map.vh
`ifndef GTOP_MAP_VH
`define GTOP_MAP_VH
`define GTOP_ADDR_CTRL 16'h003c
`define GTOP_RESET_CTRL 16'h0000
`define GTOP_WRITE_MASK 16'h8f0f
`define GTOP_BIT_TIMER_OUT_SELECT 15
`define GTOP_DIR_HI 11
`define GTOP_DIR_LO 8
`define GTOP_VAL_HI 3
`define GTOP_VAL_LO 0
`define GTOP_RESET_PERIOD 16'hffff
`endif

// file: rtl/gtop_timer.v
`timescale 1ns/1ps
module gtop_timer (
    input wire i_clk,
    input wire i_reset_n,
    input wire i_tick,
    input wire i_load,
    input wire [15:0] i_period,
    output reg o_pulse
);
`include "gtop_map.vh"
    reg [15:0] count_ff;
    reg [15:0] period_ff;
    // ----------------------------------------
    // counter
    // ----------------------------------------
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_ff <= `GTOP_RESET_PERIOD;
            period_ff <= `GTOP_RESET_PERIOD;
            o_pulse <= 1'b0;
        end else begin
            o_pulse <= 1'b0;
            if (i_load) begin
                period_ff <= i_period;
                count_ff <= i_period;
            end else if (i_tick) begin
                if (count_ff == 16'h0000) begin
                    count_ff <= period_ff;
                end else begin
                    count_ff <= count_ff - 16'h0001;
                    // pulse on the step into zero, one cycle wide
                    o_pulse <= (count_ff == 16'h0001);
                end
            end
        end
    end
endmodule // gtop_timer

// file: rtl/gtop_port.v
`timescale 1ns/1ps
module gtop_port (
    input wire i_clk,
    input wire i_reset_n,
    input wire i_wr,
    input wire i_rd,
    input wire [15:0] i_addr,
    input wire [15:0] i_wdata,
    output reg [15:0] o_rdata,
    input wire i_ext_interface_select,
    input wire i_cpu_clock_output,
    input wire i_timer_load,
    input wire [15:0] i_timer_period,
    input wire [3:0] i_pin,
    output wire [3:0] o_pin,
    output wire [3:0] o_pin_oe,
    output reg o_timer_pulse,
    output wire o_branch_input_condition
);
`include "gtop_map.vh"
    reg [15:0] ctrl_ff;
    reg [3:0] s1_ff;
    reg [3:0] s2_ff;
    reg [3:0] s3_ff;
    reg [3:0] pin_level_ff;
    reg clk_s1_ff;
    reg clk_s2_ff;
    reg clk_s3_ff;
    reg [15:0] nxt_rdata;
    wire timer_pulse;
    wire tick;
    wire [3:0] pin_direction;
    wire [3:0] pin_value;
    wire pin3_timer;
    // ----------------------------------------
    // control register
    // ----------------------------------------
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_ff <= `GTOP_RESET_CTRL;
        end else if (i_wr && i_addr == `GTOP_ADDR_CTRL) begin
            ctrl_ff <= i_wdata & `GTOP_WRITE_MASK;
        end
    end
    assign pin_direction = ctrl_ff[`GTOP_DIR_HI:`GTOP_DIR_LO];
    assign pin_value = ctrl_ff[`GTOP_VAL_HI:`GTOP_VAL_LO];
    // ----------------------------------------
    // pin synchronisers, three stages
    // ----------------------------------------
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s1_ff <= 4'h0;
            s2_ff <= 4'h0;
            s3_ff <= 4'h0;
            pin_level_ff <= 4'h0;
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
            clk_s3_ff <= 1'b0;
            o_timer_pulse <= 1'b0;
        end else begin
            s1_ff <= i_pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // a bit changes only once two stages agree
            pin_level_ff <= (s2_ff & s3_ff) | (pin_level_ff & (s2_ff | s3_ff));
            clk_s1_ff <= i_cpu_clock_output;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            o_timer_pulse <= timer_pulse;
        end
    end
    // one decrement per rising edge of the output clock
    assign tick = clk_s2_ff & ~clk_s3_ff;
    gtop_timer u_timer (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_tick(tick),
        .i_load(i_timer_load),
        .i_period(i_timer_period),
        .o_pulse(timer_pulse)
    );
    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    // timer owns pin 3 only in host-port mode
    assign pin3_timer = ctrl_ff[`GTOP_BIT_TIMER_OUT_SELECT] & ~i_ext_interface_select;
    assign o_pin = {pin3_timer ? timer_pulse : pin_value[3], pin_value[2:0]};
    assign o_pin_oe = {pin3_timer | pin_direction[3], pin_direction[2:0]};
    assign o_branch_input_condition = pin_direction[2] ? 1'b0 : pin_level_ff[2];
    // ----------------------------------------
    // read back
    // ----------------------------------------
    always @* begin
        nxt_rdata = 16'h0000;
        if (i_rd && i_addr == `GTOP_ADDR_CTRL) begin
            nxt_rdata[15] = ctrl_ff[`GTOP_BIT_TIMER_OUT_SELECT];
            nxt_rdata[11:8] = pin_direction;
            nxt_rdata[3:0] = (pin_direction & pin_value) | (~pin_direction & pin_level_ff);
            if (ctrl_ff[`GTOP_BIT_TIMER_OUT_SELECT]) begin
                nxt_rdata[3] = pin3_timer ? o_timer_pulse : pin_level_ff[3];
            end
        end
    end
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= nxt_rdata;
        end
    end
endmodule // gtop_port

// file: tb/gtop_monitor.sv
`timescale 1ns/1ps
// ----
// checks
// ----
module gtop_monitor (
    input wire i_clk, i_reset_n, i_wr, i_rd, i_ext_interface_select,
    input wire [15:0] i_addr, i_wdata, o_rdata,
    input wire [3:0] o_pin_oe, o_pin,
    input wire o_timer_pulse, o_branch_input_condition);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire hit = i_wr && i_addr == 16'h003c;
    wire own = hit && i_wdata[15] && !i_wdata[11];
    chk_dir_oe: assert property (hit |=>
        o_pin_oe[2:0] == $past(i_wdata[10:8])) else $error("dir");
    chk_val_out: assert property (hit |=> (o_pin[2:0] & o_pin_oe[2:0]) ==
        ($past(i_wdata[2:0]) & $past(i_wdata[10:8]))) else $error("val");
    chk_rd_idle: assert property (!(i_rd && i_addr == 16'h003c) |=>
        o_rdata == 16'h0) else $error("idle rd");
    chk_rsv_zero: assert property ((o_rdata & 16'h70f0) == 16'h0)
        else $error("rsv");
    chk_bio_out: assert property (o_pin_oe[2] && $past(o_pin_oe[2]) |->
        !o_branch_input_condition) else $error("bio");
    chk_timer_out_select_own: assert property (own ##1 !i_ext_interface_select |->
        o_pin_oe[3]) else $error("timer_out_select");
    chk_timer_out_select_off: assert property (own ##1 i_ext_interface_select |->
        !o_pin_oe[3]) else $error("xio");
    chk_pulse_one: assert property (o_timer_pulse |=> !o_timer_pulse)
        else $error("pulse");
    cover property (own);
    cover property (o_timer_pulse);
    cover property (i_rd ##1 o_rdata != 16'h0);
endmodule // gtop_monitor
bind gtop_port gtop_monitor gtop_monitor_i (.*);

// file: tb/gtop_board.sv
`timescale 1ns/1ps
// ----
// board
// ----
module gtop_board (input wire [3:0] i_drive, i_oe, i_ext, output wire [3:0] o_level);
    // undriven lines show the board level, no keeper
    assign o_level = (i_oe & i_drive) | (~i_oe & i_ext);
endmodule // gtop_board

// file: tb/gpio_timer_out_port_tb.sv
`timescale 1ns/1ps
// ----
// bench
// ----
module gpio_timer_out_port_tb;
    reg i_clk = 1'h0, i_reset_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0, i_timer_load = 1'h0;
    reg i_ext_interface_select = 1'h1, i_cpu_clock_output = 1'h0;
    reg [15:0] i_addr = 16'h0, i_wdata = 16'h0, i_timer_period = 16'h2, w, rv;
    reg [3:0] ext = 4'h0;
    wire [15:0] o_rdata;
    wire [3:0] i_pin, o_pin, o_pin_oe;
    wire o_timer_pulse, o_branch_input_condition;
    integer err_total = 0, comparisons = 0, i, n, m;
    gtop_port gtop_port_i (.*);
    gtop_board gtop_board_i (.i_drive(o_pin), .i_oe(o_pin_oe), .i_ext(ext), .o_level(i_pin));
    initial forever #10 i_clk = ~i_clk;
    task cyc(input integer k); begin repeat (k) @(posedge i_clk); #1; end endtask
    task chk(input [15:0] g, input [15:0] x); begin
        comparisons = comparisons + 1;
        if (g !== x) begin
            err_total = err_total + 1;
            $display("ERROR %0t got %h want %h", $time, g, x);
        end
    end endtask
    task acc(input r, input [15:0] a, input [15:0] d); begin
        i_wr = !r; i_rd = r; i_addr = a; i_wdata = d;
        cyc(1); rv = o_rdata; i_wr = 1'h0; i_rd = 1'h0; cyc(1);
    end endtask
    function [15:0] expv(input [15:0] v, input [3:0] x);
        expv = (v & 16'h8f00) | {12'h0, (v[3:0] & v[11:8]) | (x & ~v[11:8])};
    endfunction
    task report_and_stop; begin
        $display("compares %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end endtask
    initial begin
        n = $urandom(32'h6951676c);
        cyc(16); i_reset_n = 1'h1; cyc(1);
        acc(1'h1, 16'h003c, 16'h0); chk(rv, 16'h0);
        for (i = 0; i < 24; i = i + 1) begin
            n = $urandom; w = (i == 0) ? 16'hffff : n[15:0]; ext = n[19:16];
            acc(1'h0, 16'h003c, w); chk({12'h0, o_pin_oe}, {12'h0, w[11:8]});
            cyc(6); acc(1'h1, 16'h003c, 16'h0); chk(rv, expv(w, ext));
            chk({15'h0, o_branch_input_condition}, {15'h0, ~w[10] & ext[2]});
            acc(1'h1, 16'h003d, 16'hffff); chk(rv, 16'h0);
        end
        $display("pin test done");
        i_ext_interface_select = 1'h0; i_timer_load = 1'h1; cyc(1); i_timer_load = 1'h0;
        acc(1'h0, 16'h003c, 16'h8000); chk({15'h0, o_pin_oe[3]}, 16'h1);
        n = 0;
        m = 0;
        for (i = 0; i < 60; i = i + 1) begin
            i_cpu_clock_output = i[1]; cyc(1); n = n + o_timer_pulse;
            m = m + (o_pin[3] & o_pin_oe[3]);
        end
        chk({15'h0, n >= 3 && n <= 5}, 16'h1);
        chk({15'h0, m >= 3 && m <= 5}, 16'h1);
        i_ext_interface_select = 1'h1; cyc(1); chk({15'h0, o_pin_oe[3]}, 16'h0);
        $display("timer test done");
        report_and_stop;
    end
    initial begin #100000; err_total = err_total + 1; report_and_stop; end
endmodule // gpio_timer_out_port_tb
